// ---- src/dsbp_bus_port.sv ----
// Dual mode (two-wire or three-wire) programming port of the synthesizer
// Function
// RULE1: Answer only the write address set by selects
// RULE2: Pairs in either order, each internally ordered
// RULE3: Stop anywhere; apply received bytes, keep rest
// RULE4: Three-wire word carries divider and switches
// RULE5: Shift on clock fall only while enable high
// RULE6: Enable low: clock ignored, nothing shifts
// RULE7: Latch on enable fall only after nineteen pulses
// RULE8: Three-wire mode: switch one shows lock
// RULE9: Lock drives switch one on, else off
// RULE10: Three-wire mode forces high pump current
// RULE11: Divider ratio zero disables whole loop
// RULE12: Bus format detected from the signalling
// RULE13: Acknowledge matching address and each data byte
// RULE14: Divider bytes form fifteen-bit latch, top first
// RULE15: Switch bit one turns its output on
// RULE16: Byte kind by top bit, partner by position
// RULE17: Three-wire word: fifteen divider, four switch bits
`timescale 1ns/1ps
`default_nettype none

module dsbp_bus_port (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  input  wire logic                         scl_in,
  input  wire logic                         address_select_or_enable_pin,
  input  wire logic                         addr_select_bit_a,
  input  wire logic                         addr_select_bit_b,
  input  wire logic                         lock_detect,
  output logic [dsbp_pkg::SF_BITS-1:0]      scaling_factor,
  output logic                              pump_current_select,
  output logic                              divider_test_enable,
  output logic                              pump_disable_bit,
  output logic                              varicap_driver_off,
  output logic                              loop_disable,
  output logic                              switch_out_one_oe,
  output logic                              switch_out_four_oe,
  output logic                              switch_out_five_oe,
  output logic                              switch_out_six_oe,
  output logic                              switch_out_seven_oe,
  output logic                              three_wire_mode
);

  // ==========================================================================
  // Pin synchronisers
  logic [dsbp_pkg::PIN_COUNT-1:0] pin_lvl;
  logic [dsbp_pkg::PIN_COUNT-1:0] pin_rise;
  logic [dsbp_pkg::PIN_COUNT-1:0] pin_fall;

  dsbp_pin_sync #(.WIDTH(dsbp_pkg::PIN_COUNT)) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({lock_detect, addr_select_bit_b, addr_select_bit_a,
             address_select_or_enable_pin, scl_in, sda_in}),
    .level (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic sda_lvl;
  logic scl_lvl;
  logic ena_lvl;
  logic scl_fall;
  logic scl_rise;
  logic ena_rise;
  logic ena_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] own_addr;

  // Start and stop are data edges while the clock stands high
  assign sda_lvl    = pin_lvl[dsbp_pkg::PIN_SDA];
  assign scl_lvl    = pin_lvl[dsbp_pkg::PIN_SCL];
  assign ena_lvl    = pin_lvl[dsbp_pkg::PIN_ENA];
  assign scl_fall   = pin_fall[dsbp_pkg::PIN_SCL];
  assign scl_rise   = pin_rise[dsbp_pkg::PIN_SCL];
  assign ena_rise   = pin_rise[dsbp_pkg::PIN_ENA];
  assign ena_fall   = pin_fall[dsbp_pkg::PIN_ENA];
  assign start_cond = pin_fall[dsbp_pkg::PIN_SDA] & scl_lvl;
  assign stop_cond  = pin_rise[dsbp_pkg::PIN_SDA] & scl_lvl;
  assign own_addr   = {dsbp_pkg::ADDR_HIGH, pin_lvl[dsbp_pkg::PIN_SEL_A],
                       pin_lvl[dsbp_pkg::PIN_SEL_B], dsbp_pkg::ADDR_WRITE};

  // ==========================================================================
  // Bus format detection
  dsbp_pkg::dsbp_mode_e mode_ff;
  dsbp_pkg::dsbp_mode_e nxt_mode;
  logic                 tw_start;

  // The select pin is static in two-wire use, so any rise means three-wire.
  // A start is not trusted while enable is high in three-wire mode, since
  // three-wire data may legally move while the clock is high.
  assign tw_start = start_cond &
                    !(mode_ff == dsbp_pkg::MODE_THREE_WIRE && ena_lvl);

  always_comb begin
    nxt_mode = mode_ff;
    if (ena_rise) begin
      nxt_mode = dsbp_pkg::MODE_THREE_WIRE;  // RULE12
    end else if (tw_start) begin
      nxt_mode = dsbp_pkg::MODE_TWO_WIRE;    // RULE12
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ff <= dsbp_pkg::MODE_TWO_WIRE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ==========================================================================
  // Two-wire receiver
  dsbp_pkg::dsbp_tw_state_e tw_st_ff;
  dsbp_pkg::dsbp_tw_state_e nxt_tw_st;
  logic [3:0]               bit_cnt_ff;
  logic [3:0]               nxt_bit_cnt;
  logic [7:0]               shreg_ff;
  logic [7:0]               nxt_shreg;
  logic                     in_pair_ff;
  logic                     nxt_in_pair;
  logic                     kind_ff;
  logic                     nxt_kind;
  logic                     ack_ff;
  logic                     nxt_ack;
  dsbp_pkg::dsbp_cfg_s      pend_ff;
  dsbp_pkg::dsbp_cfg_s      nxt_pend;
  dsbp_pkg::dsbp_cfg_s      cfg_ff;
  logic                     tw_commit;
  logic                     byte_done;

  assign byte_done = scl_fall && (bit_cnt_ff == dsbp_pkg::BYTE_BITS);
  assign tw_commit = stop_cond && (tw_st_ff != dsbp_pkg::TW_IDLE);  // RULE3

  // A stop commits the staged copy, so a cut-short write keeps the rest
  always_comb begin
    nxt_tw_st   = tw_st_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shreg   = shreg_ff;
    nxt_in_pair = in_pair_ff;
    nxt_kind    = kind_ff;
    nxt_ack     = ack_ff;
    nxt_pend    = pend_ff;
    if (tw_start) begin
      nxt_tw_st   = dsbp_pkg::TW_ADDR;
      nxt_bit_cnt = '0;
      nxt_ack     = 1'b0;
      nxt_pend    = cfg_ff;
    end else if (stop_cond || mode_ff == dsbp_pkg::MODE_THREE_WIRE) begin
      nxt_tw_st = dsbp_pkg::TW_IDLE;
      nxt_ack   = 1'b0;
    end else begin
      case (tw_st_ff)
        dsbp_pkg::TW_ADDR, dsbp_pkg::TW_DATA: begin
          if (scl_rise) begin
            nxt_shreg   = {shreg_ff[6:0], sda_lvl};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          if (byte_done && tw_st_ff == dsbp_pkg::TW_ADDR) begin
            nxt_in_pair = 1'b0;
            if (shreg_ff == own_addr) begin
              nxt_tw_st = dsbp_pkg::TW_ACK;           // RULE1
              nxt_ack   = 1'b1;                       // RULE13
            end else begin
              nxt_tw_st = dsbp_pkg::TW_SKIP;          // RULE1
            end
          end else if (byte_done) begin
            nxt_tw_st   = dsbp_pkg::TW_ACK;
            nxt_ack     = 1'b1;                       // RULE13
            nxt_in_pair = !in_pair_ff;                // RULE16
            if (!in_pair_ff) begin
              nxt_kind = shreg_ff[dsbp_pkg::KIND_POS];  // RULE16
              if (!shreg_ff[dsbp_pkg::KIND_POS]) begin
                nxt_pend.scaling_factor[14:8] = shreg_ff[6:0];  // RULE14
              end else begin
                nxt_pend.pump_current_select =
                  shreg_ff[dsbp_pkg::PUMP_POS];
                nxt_pend.divider_test_enable =
                  shreg_ff[dsbp_pkg::TEST_POS];
                nxt_pend.pump_disable_bit    =
                  shreg_ff[dsbp_pkg::PDIS_POS];
                nxt_pend.varicap_driver_off  =
                  shreg_ff[dsbp_pkg::VOFF_POS];
              end
            end else if (!kind_ff) begin
              nxt_pend.scaling_factor[7:0] = shreg_ff;  // RULE2
            end else begin
              nxt_pend.switch_on = {shreg_ff[dsbp_pkg::SW7_POS],
                                    shreg_ff[dsbp_pkg::SW6_POS],
                                    shreg_ff[dsbp_pkg::SW5_POS],
                                    shreg_ff[dsbp_pkg::SW4_POS],
                                    shreg_ff[dsbp_pkg::SW1_POS]};  // RULE2
            end
          end
        end
        dsbp_pkg::TW_ACK: begin
          if (scl_fall) begin
            nxt_tw_st   = dsbp_pkg::TW_DATA;
            nxt_ack     = 1'b0;                       // RULE13
            nxt_bit_cnt = '0;
          end
        end
        dsbp_pkg::TW_IDLE, dsbp_pkg::TW_SKIP: begin
          nxt_ack = 1'b0;
        end
        default: begin
          nxt_tw_st = dsbp_pkg::TW_IDLE;
          nxt_ack   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tw_st_ff   <= dsbp_pkg::TW_IDLE;
      bit_cnt_ff <= '0;
      shreg_ff   <= '0;
      in_pair_ff <= 1'b0;
      kind_ff    <= 1'b0;
      ack_ff     <= 1'b0;
      pend_ff    <= dsbp_pkg::CFG_RESET;
    end else begin
      tw_st_ff   <= nxt_tw_st;
      bit_cnt_ff <= nxt_bit_cnt;
      shreg_ff   <= nxt_shreg;
      in_pair_ff <= nxt_in_pair;
      kind_ff    <= nxt_kind;
      ack_ff     <= nxt_ack;
      pend_ff    <= nxt_pend;
    end
  end

  // ==========================================================================
  // Three-wire receiver and the settings latch
  logic [dsbp_pkg::WORD3_BITS-1:0] sh3_ff;
  logic [dsbp_pkg::WORD3_BITS-1:0] nxt_sh3;
  logic [4:0]                      cnt3_ff;
  logic [4:0]                      nxt_cnt3;
  dsbp_pkg::dsbp_cfg_s             nxt_cfg;
  logic                            mode3;

  assign mode3 = (mode_ff == dsbp_pkg::MODE_THREE_WIRE);

  // Pulse count saturates so that an overlong word can never alias to 19
  always_comb begin
    nxt_sh3  = sh3_ff;
    nxt_cnt3 = cnt3_ff;
    nxt_cfg  = cfg_ff;
    if (ena_rise) begin
      nxt_cnt3 = '0;
    end else if (mode3 && ena_lvl && scl_fall) begin
      nxt_sh3 = {sh3_ff[dsbp_pkg::WORD3_BITS-2:0], sda_lvl};  // RULE5 RULE6
      if (cnt3_ff != dsbp_pkg::WORD3_SAT) begin
        nxt_cnt3 = cnt3_ff + 5'h1;
      end
    end
    if (tw_commit) begin
      nxt_cfg = pend_ff;                                        // RULE3
    end else if (mode3 && ena_fall &&
                 cnt3_ff == dsbp_pkg::WORD3_COUNT) begin         // RULE7
      nxt_cfg.scaling_factor    = sh3_ff[18:4];                 // RULE4 RULE17
      nxt_cfg.switch_on[4:1]    = sh3_ff[3:0];                  // RULE17
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sh3_ff  <= '0;
      cnt3_ff <= '0;
      cfg_ff  <= dsbp_pkg::CFG_RESET;
    end else begin
      sh3_ff  <= nxt_sh3;
      cnt3_ff <= nxt_cnt3;
      cfg_ff  <= nxt_cfg;
    end
  end

  // ==========================================================================
  // Registered outputs
  logic                            sda_oe_ff;
  logic                            pump_ff;
  logic                            loop_dis_ff;
  logic                            mode_out_ff;
  logic [dsbp_pkg::SW_BITS-1:0]    sw_oe_ff;
  logic [dsbp_pkg::SW_BITS-1:0]    nxt_sw_oe;
  dsbp_pkg::dsbp_cfg_s             cfg_out_ff;

  // Switch one is lent to the lock flag while three-wire mode holds
  always_comb begin
    nxt_sw_oe = cfg_ff.switch_on;                               // RULE15
    if (mode3) begin
      nxt_sw_oe[dsbp_pkg::SWI_ONE] = pin_lvl[dsbp_pkg::PIN_LOCK]; // RULE8 RULE9
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_oe_ff   <= 1'b0;
      pump_ff     <= 1'b0;
      loop_dis_ff <= 1'b0;
      mode_out_ff <= 1'b0;
      sw_oe_ff    <= '0;
      cfg_out_ff  <= dsbp_pkg::CFG_RESET;
    end else begin
      sda_oe_ff   <= ack_ff;
      pump_ff     <= mode3 | cfg_ff.pump_current_select;       // RULE10
      loop_dis_ff <= (cfg_ff.scaling_factor == '0);            // RULE11
      mode_out_ff <= mode3;
      sw_oe_ff    <= nxt_sw_oe;
      cfg_out_ff  <= cfg_ff;
    end
  end

  // The pin is only ever pulled low, never driven high
  assign sda_out             = 1'b0;
  assign sda_oe              = sda_oe_ff;
  assign scaling_factor      = cfg_out_ff.scaling_factor;
  assign pump_current_select = pump_ff;
  assign divider_test_enable = cfg_out_ff.divider_test_enable;
  assign pump_disable_bit    = cfg_out_ff.pump_disable_bit;
  assign varicap_driver_off  = cfg_out_ff.varicap_driver_off;
  assign loop_disable        = loop_dis_ff;
  assign switch_out_one_oe   = sw_oe_ff[dsbp_pkg::SWI_ONE];
  assign switch_out_four_oe  = sw_oe_ff[dsbp_pkg::SWI_FOUR];
  assign switch_out_five_oe  = sw_oe_ff[dsbp_pkg::SWI_FIVE];
  assign switch_out_six_oe   = sw_oe_ff[dsbp_pkg::SWI_SIX];
  assign switch_out_seven_oe = sw_oe_ff[dsbp_pkg::SWI_SEVEN];
  assign three_wire_mode     = mode_out_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_addr_hit;
    tw_st_ff == dsbp_pkg::TW_ADDR && byte_done && !tw_start &&
    !stop_cond && !mode3 && shreg_ff == own_addr;
  endsequence

  sequence s_ack_end;
    tw_st_ff == dsbp_pkg::TW_ACK && scl_fall && !tw_start && !stop_cond;
  endsequence

  a_addr_ack_drive: assert property (s_addr_hit |=> ##1 sda_oe_ff) // RULE1
    else $error("matching address not acknowledged");
  a_addr_miss_quiet: assert property (  // RULE1
    tw_st_ff == dsbp_pkg::TW_ADDR && byte_done && !tw_start && !stop_cond &&
    !mode3 && shreg_ff != own_addr |=> tw_st_ff == dsbp_pkg::TW_SKIP)
    else $error("foreign address was accepted");
  a_ack_release: assert property (s_ack_end |=> ##1 !sda_oe_ff) // RULE13
    else $error("acknowledge not released after ninth clock");
  a_stop_apply: assert property (  // RULE3
    tw_commit |=> cfg_ff == $past(pend_ff))
    else $error("stop did not apply received bytes");
  a_div_high_byte: assert property (  // RULE14
    tw_st_ff == dsbp_pkg::TW_DATA && byte_done && !tw_start && !stop_cond &&
    !mode3 && !in_pair_ff && !shreg_ff[7]
    |=> pend_ff.scaling_factor[14:8] == $past(shreg_ff[6:0]))
    else $error("first divider byte misplaced");
  a_word_latch: assert property (  // RULE7
    mode3 && ena_fall && !tw_commit && cnt3_ff == dsbp_pkg::WORD3_COUNT
    |=> cfg_ff.scaling_factor == $past(sh3_ff[18:4]))
    else $error("nineteen-bit word not latched");
  a_word_discard: assert property (  // RULE7
    mode3 && ena_fall && cnt3_ff != dsbp_pkg::WORD3_COUNT && !tw_commit
    |=> $stable(cfg_ff))
    else $error("short or long word was latched");
  a_shift_gated: assert property (  // RULE6
    !ena_lvl && !ena_rise |=> $stable(sh3_ff))
    else $error("shift register moved with enable low");
  a_shift_sample: assert property (  // RULE5
    mode3 && ena_lvl && scl_fall && !ena_rise
    |=> sh3_ff[0] == $past(sda_lvl))
    else $error("data bit not shifted on clock fall");
  a_pump_high: assert property (mode3 ##1 mode3 |=> pump_ff) // RULE10
    else $error("three-wire mode without high pump current");
  a_lock_follow: assert property (  // RULE8
    mode3 |=> switch_out_one_oe == $past(pin_lvl[dsbp_pkg::PIN_LOCK]))
    else $error("switch one does not follow lock flag");
  a_zero_ratio: assert property (  // RULE11
    cfg_ff.scaling_factor == '0 |=> loop_disable)
    else $error("zero ratio did not disable loop");
  a_mode_detect: assert property (ena_rise |=> mode3 [*2]) // RULE12
    else $error("enable rise did not select three-wire mode");

endmodule
`default_nettype wire

// ---- src/dsbp_pkg.sv ----
// Shared constants, types and field layout of the dual mode bus port
package dsbp_pkg;

  // ==========================================================================
  // Two-wire address byte: fixed high bits, select bits, write bit
  localparam logic [4:0] ADDR_HIGH      = 5'h18;
  localparam logic       ADDR_WRITE     = 1'h0;

  // ==========================================================================
  // Field positions within the two-wire data bytes
  localparam int         KIND_POS       = 7;  // 0 divider pair, 1 control pair
  localparam int         PUMP_POS       = 6;
  localparam int         TEST_POS       = 5;
  localparam int         PDIS_POS       = 4;
  localparam int         VOFF_POS       = 0;
  localparam int         SW7_POS        = 7;
  localparam int         SW6_POS        = 6;
  localparam int         SW5_POS        = 5;
  localparam int         SW4_POS        = 4;
  localparam int         SW1_POS        = 1;

  // ==========================================================================
  // Word and counter sizes
  localparam int         SF_BITS        = 15;
  localparam int         SW_BITS        = 5;
  localparam int         WORD3_BITS     = 19;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [4:0] WORD3_COUNT    = 5'h13;  // Exactly nineteen pulses
  localparam logic [4:0] WORD3_SAT      = 5'h14;  // Sticks once overrun
  localparam logic [1:0] PRIME_CYCLES   = 2'h3;

  // ==========================================================================
  // Switch vector order inside the settings struct
  localparam int         SWI_ONE        = 0;
  localparam int         SWI_FOUR       = 1;
  localparam int         SWI_FIVE       = 2;
  localparam int         SWI_SIX        = 3;
  localparam int         SWI_SEVEN      = 4;

  // ==========================================================================
  // Bit positions of the synchronised pin vector
  localparam int         PIN_SDA        = 0;
  localparam int         PIN_SCL        = 1;
  localparam int         PIN_ENA        = 2;
  localparam int         PIN_SEL_A      = 3;
  localparam int         PIN_SEL_B      = 4;
  localparam int         PIN_LOCK       = 5;
  localparam int         PIN_COUNT      = 6;

  // ==========================================================================
  // Types
  typedef enum logic {MODE_TWO_WIRE, MODE_THREE_WIRE} dsbp_mode_e;

  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_DATA, TW_ACK, TW_SKIP
  } dsbp_tw_state_e;

  typedef struct packed {
    logic [SF_BITS-1:0] scaling_factor;
    logic               pump_current_select;
    logic               divider_test_enable;
    logic               pump_disable_bit;
    logic               varicap_driver_off;
    logic [SW_BITS-1:0] switch_on;  // {seven, six, five, four, one}
  } dsbp_cfg_s;

  localparam dsbp_cfg_s CFG_RESET = '0;

endpackage

// ---- src/dsbp_pin_sync.sv ----
// Two-stage pin synchroniser with edge pulses for a vector of pins
`timescale 1ns/1ps
`default_nettype none

module dsbp_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [1:0]       prime_ff;
  logic [1:0]       nxt_prime;

  // ==========================================================================
  // Edges are held back until the chain has filled, so reset gives none
  always_comb begin
    nxt_prime = prime_ff;
    if (prime_ff != dsbp_pkg::PRIME_CYCLES) begin
      nxt_prime = prime_ff + 2'h1;
    end
  end

  // Meta stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff  <= '0;
      sync_ff  <= '0;
      prev_ff  <= '0;
      prime_ff <= '0;
    end else begin
      meta_ff  <= din;
      sync_ff  <= meta_ff;
      prev_ff  <= sync_ff;
      prime_ff <= nxt_prime;
    end
  end

  // Edge pulses last one clock
  assign level = sync_ff;
  assign rise  = (prime_ff == dsbp_pkg::PRIME_CYCLES) ? (sync_ff & ~prev_ff)
                                                      : '0;
  assign fall  = (prime_ff == dsbp_pkg::PRIME_CYCLES) ? (~sync_ff & prev_ff)
                                                      : '0;

endmodule
`default_nettype wire

// ---- tb/dsbp_bus_master.sv ----
// Bus master model: drives two-wire and three-wire programming frames
`timescale 1ns/1ps
`default_nettype none

module dsbp_bus_master (
  input  wire logic clock,
  input  wire logic sda_line,
  output var logic  sda_drv,
  output var logic  scl_drv,
  output var logic  ena_drv
);
  // ==========
  // Lines released to the pull-up level, enable low
  initial begin
    sda_drv = 1'b1;
    scl_drv = 1'b1;
    ena_drv = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One 125 ns bus clock; data only moves while the clock is low
  task automatic pulse(input logic b);
    sda_drv = b;
    tick(7);
    scl_drv = 1'b1;
    tick(12);
    scl_drv = 1'b0;
    tick(6);
  endtask

  // Eight bits MSB first, then release data and sample the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    sda_drv = 1'b1;
    tick(7);
    scl_drv = 1'b1;
    tick(6);
    ack = ~sda_line;
    tick(6);
    scl_drv = 1'b0;
    tick(6);
  endtask

  // ==========
  // Two-wire write: start, n bytes from the top of s, stop anywhere
  task automatic frame2(input logic [39:0] s, input int n,
                        output logic [4:0] acks);
    logic a;
    acks = 5'h00;
    tick(12);
    sda_drv = 1'b0;
    tick(12);
    scl_drv = 1'b0;
    tick(6);
    for (int i = 0; i < n; i++) begin
      send_byte(s[39-8*i -: 8], a);
      acks[4-i] = a;
    end
    sda_drv = 1'b0;
    tick(6);
    scl_drv = 1'b1;
    tick(12);
    sda_drv = 1'b1;
    tick(25);
  endtask

  // Three-wire word; clock idles low so no start or stop is formed
  task automatic frame3(input logic [19:0] w, input int n, input int pre);
    scl_drv = 1'b0;
    tick(6);
    repeat (pre) pulse(1'b0);
    ena_drv = 1'b1;
    tick(10);
    for (int i = n - 1; i >= 0; i--) pulse(w[i]);
    ena_drv = 1'b0;
    tick(6);
    sda_drv = 1'b1;
    tick(3);
    scl_drv = 1'b1;
    tick(20);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench of the dual mode programming port
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        sel_a = 1'b0;
  logic        sel_b = 1'b0;
  logic        lock  = 1'b0;
  logic        sda_d, scl_d, ena_d, sda_out, sda_oe, ld, mode3;
  logic        pump, test, pdis, voff, s1, s4, s5, s6, s7;
  logic [14:0] sf, e_sf;
  logic [3:0]  e_ctl;
  logic [4:0]  e_sw, acks;
  logic [7:0]  adr;
  logic        e_mode;
  int          err_total   = 0;
  int          checks_done = 0;
  wire logic   sda_w = sda_d & (sda_oe ? sda_out : 1'b1);

  always #2.5 clock = ~clock;

  dsbp_bus_master master (.clock(clock), .sda_line(sda_w), .sda_drv(sda_d),
    .scl_drv(scl_d), .ena_drv(ena_d));

  dsbp_bus_port DUT (.clock(clock), .rst(rst), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_d),
    .address_select_or_enable_pin(ena_d), .addr_select_bit_a(sel_a),
    .addr_select_bit_b(sel_b), .lock_detect(lock), .scaling_factor(sf),
    .pump_current_select(pump), .divider_test_enable(test),
    .pump_disable_bit(pdis), .varicap_driver_off(voff), .loop_disable(ld),
    .switch_out_one_oe(s1), .switch_out_four_oe(s4),
    .switch_out_five_oe(s5), .switch_out_six_oe(s6),
    .switch_out_seven_oe(s7), .three_wire_mode(mode3));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========
  // Compare every setting output with the expected state
  task automatic expect_outputs();
    logic [3:0] c;
    logic [4:0] w;
    c = {e_ctl[3] | e_mode, e_ctl[2:0]};
    w = {e_sw[4:1], e_mode ? lock : e_sw[0]};
    check(32'(sf), 32'(e_sf));
    check(32'({pump, test, pdis, voff}), 32'(c));
    check(32'({s7, s6, s5, s4, s1}), 32'(w));
    check(32'(ld), 32'(e_sf == 15'h0));
    check(32'(mode3), 32'(e_mode));
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    give_verdict();
  end

  // ==========
  // Main sequence
  initial begin
    {e_sf, e_ctl, e_sw, e_mode} = '0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    expect_outputs();
    // Each select setting: own address taken, a foreign or read one refused
    for (int k = 0; k < 4; k++) begin
      {sel_a, sel_b} = 2'(k);
      master.frame2({5'h18, 2'(k), 1'b0, 8'(k), 8'h55, 16'h0}, 3, acks);
      check(32'(acks), 32'h1c);
      e_sf = {7'(k), 8'h55};
      adr = k < 2 ? {5'h18, 2'(k + 1), 1'b0} : {5'h18, 2'(k), 1'b1};
      master.frame2({adr, 8'h7f, 8'hff, 16'h0}, 3, acks);
      check(32'(acks), 32'h00);
      expect_outputs();
    end
    // Control pair ahead of divider pair
    {sel_a, sel_b} = 2'b01;
    master.frame2({8'hc2, 8'hd1, 8'h92, 8'h12, 8'h34}, 5, acks);
    check(32'(acks), 32'h1f);
    {e_sf, e_ctl, e_sw} = {15'h1234, 4'hb, 5'h13};
    expect_outputs();
    // Stop right after the first control byte
    master.frame2({8'hc2, 8'h00, 8'h00, 8'ha0, 8'h00}, 4, acks);
    {e_sf, e_ctl} = {15'h0, 4'h4};
    expect_outputs();
    // Three-wire word with lock shown on switch one
    lock = 1'b1;
    master.frame3(20'h5a5a5, 19, 0);
    {e_sf, e_sw, e_mode} = {15'h5a5a, 4'h5, e_sw[0], 1'b1};
    expect_outputs();
    lock = 1'b0;
    repeat (8) @(negedge clock);
    expect_outputs();
    // Short and long words are dropped; clocks with enable low ignored
    master.frame3(20'h12345, 18, 0);
    master.frame3(20'h12345, 20, 4);
    expect_outputs();
    master.frame3(20'h0, 19, 0);
    {e_sf, e_sw} = {15'h0, 4'h0, e_sw[0]};
    expect_outputs();
    // A two-wire write takes the port back and frees switch one from the lock flag
    lock = 1'b1;
    master.frame2({8'hc2, 8'hc0, 8'hf0, 16'h0}, 3, acks);
    {e_ctl, e_sw, e_mode} = {4'h8, 5'h1e, 1'b0};
    expect_outputs();
    give_verdict();
  end
endmodule
`default_nettype wire
